// *** rtl/esc_pkg.sv ***
// Constants and types for the Sa6 change interrupt status block
package esc_pkg;

    // Bus geometry
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned REG_W  = 8;

    // Register indexes; byte address is four times the index
    localparam logic [7:0] LB_ENABLE_IDX  = 8'h0B;
    localparam logic [7:0] SA6_STATUS_IDX = 8'h0C;
    localparam logic [7:0] SA6_ENABLE_IDX = 8'h0D;
    localparam logic [ADDR_W-1:0] LB_ENABLE_ADDR  = ADDR_W'(LB_ENABLE_IDX * 4);
    localparam logic [ADDR_W-1:0] SA6_STATUS_ADDR = ADDR_W'(SA6_STATUS_IDX * 4);
    localparam logic [ADDR_W-1:0] SA6_ENABLE_ADDR = ADDR_W'(SA6_ENABLE_IDX * 4);

    // Number of watched Sa6 patterns and the lowest flag bit they occupy
    localparam int unsigned NPAT     = 5;
    localparam int unsigned FLAG_LSB = 3;

    // Watched codes, index 4 sits in bit 7 down to index 0 in bit 3
    localparam logic [NPAT-1:0][3:0] SA6_PAT = {4'hF, 4'hE, 4'hC, 4'hA, 4'h8};

    // Reset values
    localparam logic [NPAT-1:0]  FLAG_RESET = 5'h00;
    localparam logic [NPAT-1:0]  ENAB_RESET = 5'h00;
    localparam logic [REG_W-1:0] LB_RESET   = 8'h00;
    localparam logic [3:0]       CODE_RESET = 4'h0;

    // Writable bits of the loopback code enable register in E1 mode
    localparam logic [REG_W-1:0] LB_WR_MASK = 8'hD0;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Write request held until both halves have arrived
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [REG_W-1:0]  data;
        logic              strb0;
    } esc_wreq_t;

endpackage

// *** rtl/esc_top.sv ***
// Sa6 change status flags, enables and interrupt behind an AXI4-Lite slave
// What this block does
// - Status bit 7 sets when the Sa6 code becomes or stops being 1111.
// - Status bit 6 sets when the Sa6 code becomes or stops being 1110.
// - Status bit 5 sets when the Sa6 code becomes or stops being 1100.
// - Status bit 4 sets when the Sa6 code becomes or stops being 1010.
// - Status bit 3 sets when the Sa6 code becomes or stops being 1000.
// - Flags hold until software reads status; the read returns then clears them.
// - A flag of 1 means its change happened since the previous read.
// - Interrupt raised for a pattern change only when that pattern is enabled.
// - All five change flags reset to zero.
// - Separate read-write enable register, same bit positions, resetting to disabled.
//
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module esc_top
    import esc_pkg::*;
(
    // Clock and reset
    input  wire logic              CLK,
    input  wire logic              NRST,
    // Debounced Sa6 code from the receive framer, same clock
    input  wire logic [3:0]        SA6_CODE,
    // Write address channel
    input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
    input  wire logic              S_AXI_AWVALID,
    output var  logic              S_AXI_AWREADY,
    // Write data channel
    input  wire logic [DATA_W-1:0] S_AXI_WDATA,
    input  wire logic [3:0]        S_AXI_WSTRB,
    input  wire logic              S_AXI_WVALID,
    output var  logic              S_AXI_WREADY,
    // Write response channel
    output var  logic [1:0]        S_AXI_BRESP,
    output var  logic              S_AXI_BVALID,
    input  wire logic              S_AXI_BREADY,
    // Read address channel
    input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
    input  wire logic              S_AXI_ARVALID,
    output var  logic              S_AXI_ARREADY,
    // Read data channel
    output var  logic [DATA_W-1:0] S_AXI_RDATA,
    output var  logic [1:0]        S_AXI_RRESP,
    output var  logic              S_AXI_RVALID,
    input  wire logic              S_AXI_RREADY,
    // Channel interrupt request
    output var  logic              IRQ
);

    // State
    logic [3:0]       code_q;
    logic             armed_q;
    logic [NPAT-1:0]  flags_q;
    logic [NPAT-1:0]  flags_d;
    logic [NPAT-1:0]  enab_q;
    logic [NPAT-1:0]  enab_d;
    logic [REG_W-1:0] lb_q;
    logic [REG_W-1:0] lb_d;
    esc_wreq_t        wreq_q;
    esc_wreq_t        wreq_d;
    logic             aw_full_q;
    logic             w_full_q;
    logic             aw_full_d;
    logic             w_full_d;
    logic             bvalid_d;
    logic             rvalid_d;
    logic [1:0]       bresp_d;
    logic [DATA_W-1:0] rdata_d;
    logic [1:0]       rresp_d;

    // Pattern matches now and on the previous cycle
    logic [NPAT-1:0]  match_now;
    logic [NPAT-1:0]  match_old;
    logic [NPAT-1:0]  evt;

    genvar gi;
    generate
        for (gi = 0; gi < NPAT; gi++) begin : g_pat
            assign match_now[gi] = (SA6_CODE == SA6_PAT[gi]);
            assign match_old[gi] = (code_q == SA6_PAT[gi]);
        end
    endgenerate

    // change detect
    // Entering or leaving a pattern both count; first cycle after reset only primes
    assign evt = armed_q ? (match_now ^ match_old) : '0;

    // Bus handshakes
    wire aw_hs = S_AXI_AWVALID && S_AXI_AWREADY;
    wire w_hs  = S_AXI_WVALID && S_AXI_WREADY;
    wire ar_hs = S_AXI_ARVALID && S_AXI_ARREADY;
    wire do_wr = aw_full_q && w_full_q && !S_AXI_BVALID;

    // Read address decode
    wire rd_lb   = (S_AXI_ARADDR == LB_ENABLE_ADDR);
    wire rd_stat = (S_AXI_ARADDR == SA6_STATUS_ADDR);
    wire rd_enab = (S_AXI_ARADDR == SA6_ENABLE_ADDR);
    wire rd_hit  = rd_lb || rd_stat || rd_enab;
    wire st_rd   = ar_hs && rd_stat;

    // Write address decode, status is read-only so writes there are accepted and dropped
    wire wr_lb   = (wreq_q.addr == LB_ENABLE_ADDR);
    wire wr_stat = (wreq_q.addr == SA6_STATUS_ADDR);
    wire wr_enab = (wreq_q.addr == SA6_ENABLE_ADDR);
    wire wr_hit  = wr_lb || wr_stat || wr_enab;
    wire wr_lane = do_wr && wreq_q.strb0;

    // set wins over read clear
    // An event landing in the clearing cycle survives to the next read
    assign flags_d = (st_rd ? '0 : flags_q) | evt;

    assign enab_d = (wr_lane && wr_enab) ?
                    wreq_q.data[FLAG_LSB +: NPAT] : enab_q;

    // only the E1 bits of the loopback enable take writes
    assign lb_d = (wr_lane && wr_lb) ?
                  ((wreq_q.data & LB_WR_MASK) | (lb_q & ~LB_WR_MASK)) : lb_q;

    // Write capture, each half held until the pair is complete
    assign wreq_d.addr  = aw_hs ? S_AXI_AWADDR : wreq_q.addr;
    assign wreq_d.data  = w_hs ? S_AXI_WDATA[REG_W-1:0] : wreq_q.data;
    assign wreq_d.strb0 = w_hs ? S_AXI_WSTRB[0] : wreq_q.strb0;
    assign aw_full_d    = aw_hs || (aw_full_q && !do_wr);
    assign w_full_d     = w_hs || (w_full_q && !do_wr);
    assign bvalid_d     = do_wr || (S_AXI_BVALID && !S_AXI_BREADY);
    assign bresp_d      = do_wr ? (wr_hit ? RESP_OKAY : RESP_SLVERR) : S_AXI_BRESP;

    // Read data path; status is sampled before the clear takes effect
    assign rvalid_d = ar_hs || (S_AXI_RVALID && !S_AXI_RREADY);
    assign rresp_d  = ar_hs ? (rd_hit ? RESP_OKAY : RESP_SLVERR) : S_AXI_RRESP;
    assign rdata_d  = !ar_hs ? S_AXI_RDATA :
                      rd_stat ? DATA_W'({flags_q, {FLAG_LSB{1'b0}}}) :
                      rd_enab ? DATA_W'({enab_q, {FLAG_LSB{1'b0}}}) :
                      rd_lb   ? DATA_W'(lb_q) : '0;

    wire irq_d = |(flags_d & enab_d);

    // Detector and status registers
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            code_q  <= CODE_RESET;
            armed_q <= 1'b0;
            flags_q <= FLAG_RESET;
            enab_q  <= ENAB_RESET;
            lb_q    <= LB_RESET;
            IRQ     <= 1'b0;
        end else begin
            code_q  <= SA6_CODE;
            armed_q <= 1'b1;
            flags_q <= flags_d;
            enab_q  <= enab_d;
            lb_q    <= lb_d;
            IRQ     <= irq_d;
        end
    end

    // Bus slave registers
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            wreq_q        <= '0;
            aw_full_q     <= 1'b0;
            w_full_q      <= 1'b0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY  <= 1'b0;
            S_AXI_BVALID  <= 1'b0;
            S_AXI_BRESP   <= RESP_OKAY;
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RRESP   <= RESP_OKAY;
            S_AXI_RDATA   <= '0;
        end else begin
            wreq_q        <= wreq_d;
            aw_full_q     <= aw_full_d;
            w_full_q      <= w_full_d;
            S_AXI_AWREADY <= !aw_full_d;
            S_AXI_WREADY  <= !w_full_d;
            S_AXI_BVALID  <= bvalid_d;
            S_AXI_BRESP   <= bresp_d;
            S_AXI_ARREADY <= !rvalid_d;
            S_AXI_RVALID  <= rvalid_d;
            S_AXI_RRESP   <= rresp_d;
            S_AXI_RDATA   <= rdata_d;
        end
    end

    // Helper for read-back checks
    logic rd_lb_q;
    logic rd_stat_q;
    logic [NPAT-1:0] flags_at_rd_q;
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            rd_lb_q       <= 1'b0;
            rd_stat_q     <= 1'b0;
            flags_at_rd_q <= '0;
        end else begin
            rd_lb_q       <= ar_hs && rd_lb;
            rd_stat_q     <= st_rd;
            flags_at_rd_q <= ar_hs ? flags_q : flags_at_rd_q;
        end
    end

    AST_ALL_ONES_SET: assert property (@(posedge CLK) disable iff (!NRST)
        (armed_q && (match_now[4] != match_old[4])) |=> flags_q[4])
        else $error("1111 change did not set bit 7");

    AST_PAT_E_SET: assert property (@(posedge CLK) disable iff (!NRST)
        (armed_q && (SA6_CODE == 4'hE) != (code_q == 4'hE)) |=> flags_q[3])
        else $error("1110 change did not set bit 6");

    AST_PAT_C_SET: assert property (@(posedge CLK) disable iff (!NRST)
        (armed_q && $changed(SA6_CODE == 4'hC)) |=> flags_q[2])
        else $error("1100 change did not set bit 5");

    AST_PAT_A_SET: assert property (@(posedge CLK) disable iff (!NRST)
        (armed_q && code_q == 4'hA && SA6_CODE != 4'hA) |=> flags_q[1] [*1])
        else $error("leaving 1010 did not set bit 4");

    AST_PAT_8_SET: assert property (@(posedge CLK) disable iff (!NRST)
        (armed_q && code_q != 4'h8 && SA6_CODE == 4'h8) ##1 !st_rd |=> flags_q[0])
        else $error("entering 1000 did not set bit 3");

    AST_FLAGS_STICKY: assert property (@(posedge CLK) disable iff (!NRST)
        !st_rd |=> ((flags_q & $past(flags_q)) == $past(flags_q)))
        else $error("status flag dropped without a read");

    AST_READ_CLEARS: assert property (@(posedge CLK) disable iff (!NRST)
        (st_rd && evt == '0) |=> (flags_q == '0))
        else $error("status read did not clear flags");

    // read returns flags seen at the read
    AST_READ_RETURNS: assert property (@(posedge CLK) disable iff (!NRST)
        rd_stat_q |-> (S_AXI_RDATA[REG_W-1:FLAG_LSB] == flags_at_rd_q)
                      && (S_AXI_RDATA[FLAG_LSB-1:0] == '0))
        else $error("status read returned wrong flags");

    AST_IRQ_MATCH: assert property (@(posedge CLK) disable iff (!NRST)
        IRQ == |(flags_q & enab_q))
        else $error("interrupt disagrees with enabled flags");

    AST_IRQ_GATED: assert property (@(posedge CLK) disable iff (!NRST)
        ((flags_q & enab_q) == '0) |-> !IRQ)
        else $error("interrupt raised for a disabled pattern");

    AST_RESET_VALUES: assert property (@(posedge CLK) disable iff (!NRST)
        $past(!NRST) |-> (flags_q == '0) && (enab_q == '0) && !IRQ)
        else $error("flags or enables not cleared by reset");

    AST_ENABLE_WRITE: assert property (@(posedge CLK) disable iff (!NRST)
        (wr_lane && wr_enab) |=> (enab_q == $past(wreq_q.data[REG_W-1:FLAG_LSB])))
        else $error("enable write not stored");

    AST_LB_UNUSED_ZERO: assert property (@(posedge CLK) disable iff (!NRST)
        rd_lb_q |-> ((S_AXI_RDATA[REG_W-1:0] & ~LB_WR_MASK) == '0))
        else $error("unused loopback enable bit read non-zero");

    // writes reach only the E1 loopback enable bits
    AST_LB_WRITE: assert property (@(posedge CLK) disable iff (!NRST)
        (wr_lane && wr_lb) |=> (lb_q == ($past(wreq_q.data) & LB_WR_MASK)))
        else $error("loopback enable write stored wrong bits");

    // enables change only through a write
    AST_ENABLE_HOLD: assert property (@(posedge CLK) disable iff (!NRST)
        !(wr_lane && wr_enab) |=> $stable(enab_q))
        else $error("enable register changed without a write");

    // no new flag while the code keeps its value
    AST_NO_SPURIOUS: assert property (@(posedge CLK) disable iff (!NRST)
        (SA6_CODE == code_q && !st_rd) |=> $stable(flags_q))
        else $error("status flag changed without a code change");

    AST_READ_HOLDS: assert property (@(posedge CLK) disable iff (!NRST)
        (S_AXI_RVALID && !S_AXI_RREADY) |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read data dropped before it was taken");

    AST_READ_ANSWER: assert property (@(posedge CLK) disable iff (!NRST)
        st_rd |=> S_AXI_RVALID && (S_AXI_RRESP == RESP_OKAY))
        else $error("status read not answered");

    AST_WRITE_ANSWER: assert property (@(posedge CLK) disable iff (!NRST)
        do_wr |=> S_AXI_BVALID)
        else $error("write not answered");

    AST_WRITE_HOLDS: assert property (@(posedge CLK) disable iff (!NRST)
        (S_AXI_BVALID && !S_AXI_BREADY) |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
        else $error("write answer dropped before it was taken");

endmodule

`default_nettype wire

// *** tb/esc_top_test.sv ***
// Self-checking bench for the Sa6 change status block
`timescale 1ns/1ps
`default_nettype none

module esc_top_test
    import esc_pkg::*;
;
    logic        clk, nrst, awvalid, wvalid, bready, arvalid, rready;
    logic [3:0]  sa6, wstrb;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, seed;
    logic [1:0]  bresp, rresp, resp;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic [4:0]  exp_f, en;
    logic [31:0] d;
    logic [3:0]  strb_use;
    int          err_count, tests_run;

    esc_top u_dut (
        .CLK(clk), .NRST(nrst), .SA6_CODE(sa6),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .IRQ(irq)
    );

    // Free running 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Verdict and end of run, shared by the timeout path
    task automatic end_sim();
        if (err_count == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Xorshift source with a fixed start so runs repeat
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Which watched codes a value matches, bit 4 for 1111 down to bit 0 for 1000
    function automatic logic [4:0] hit(input logic [3:0] c);
        return {c == 4'hF, c == 4'hE, c == 4'hC, c == 4'hA, c == 4'h8};
    endfunction

    // Bus write: both halves offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
        logic aw, w, done;
        aw = 1'b0;
        w = 1'b0;
        done = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        wstrb <= strb_use;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 50 && !done; n++) begin
            @(posedge clk);
            if (!aw && awready) begin
                aw = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w && wready) begin
                w = 1'b1;
                wvalid <= 1'b0;
            end
            if (bvalid && bready) begin
                r = bresp;
                bready <= 1'b0;
                done = 1'b1;
            end
        end
        if (!done) begin
            err_count++;
            end_sim();
        end
        if (a == SA6_ENABLE_ADDR && strb_use[0]) en = v[7:3];
    endtask

    // Bus read, ready held until the data beat is sampled
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
        logic done;
        done = 1'b0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 50 && !done; n++) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
                v = rdata;
                r = rresp;
                rready <= 1'b0;
                done = 1'b1;
            end
        end
        if (!done) begin
            err_count++;
            end_sim();
        end
    endtask

    // New code for the framer; the bench model notes every match change
    task automatic setc(input logic [3:0] c);
        exp_f = exp_f | (hit(sa6) ^ hit(c));
        sa6 <= c;
        @(posedge clk);
    endtask

    // Settle, check interrupt and status, then check the read cleared all
    task automatic settle_check();
        repeat (3) @(posedge clk);
        chk("irq", {31'h0, irq}, {31'h0, |(exp_f & en)});
        rd(SA6_STATUS_ADDR, d, resp);
        chk("status", d, {24'h0, exp_f, 3'h0});
        chk("status resp", {30'h0, resp}, {30'h0, RESP_OKAY});
        exp_f = 5'h00;
        rd(SA6_STATUS_ADDR, d, resp);
        chk("status cleared", d, 32'h0);
        chk("irq dropped", {31'h0, irq}, 32'h0);
    endtask

    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata, wstrb, sa6} = '0;
        nrst = 1'b0;
        seed = 32'hFD631E0F;
        strb_use = 4'hF;
        exp_f = 5'h00;
        en = 5'h00;
        err_count = 0;
        tests_run = 0;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        rd(SA6_STATUS_ADDR, d, resp);
        chk("status reset", d, 32'h0);
        rd(SA6_ENABLE_ADDR, d, resp);
        chk("enable reset", d, 32'h0);
        rd(8'hFC, d, resp);
        chk("unmapped resp", {30'h0, resp}, {30'h0, RESP_SLVERR});
        wr(8'hFC, 32'hFF, resp);
        chk("unmapped wr resp", {30'h0, resp}, {30'h0, RESP_SLVERR});
        wr(SA6_ENABLE_ADDR, 32'hFF, resp);
        rd(SA6_ENABLE_ADDR, d, resp);
        chk("enable rw", d, 32'hF8);
        wr(LB_ENABLE_ADDR, 32'hFF, resp);
        rd(LB_ENABLE_ADDR, d, resp);
        chk("lb enable", d, 32'hD0);
        // Each code in and out, enable on own bit then on a neighbour's
        for (int i = 0; i < 5; i++) begin
            wr(SA6_ENABLE_ADDR, 32'h8 << i, resp);
            setc(SA6_PAT[i]);
            settle_check();
            wr(SA6_ENABLE_ADDR, 32'h8 << ((i + 1) % 5), resp);
            setc(4'h0);
            settle_check();
        end
        // Random code bursts, random enables, status writes ignored
        for (int k = 0; k < 40; k++) begin
            wr(SA6_ENABLE_ADDR, rnd() & 32'hFF, resp);
            for (int j = rnd() % 6; j >= 0; j--) begin
                d = rnd();
                setc(d[3] ? SA6_PAT[d[10:8] % 5] : d[7:4]);
            end
            wr(SA6_STATUS_ADDR, 32'hFF, resp);
            chk("status wr resp", {30'h0, resp}, {30'h0, RESP_OKAY});
            settle_check();
        end
        // a write without byte lane 0 leaves the enables alone
        strb_use = 4'hE;
        wr(SA6_ENABLE_ADDR, 32'h0, resp);
        strb_use = 4'hF;
        chk("lane0 off wr resp", {30'h0, resp}, {30'h0, RESP_OKAY});
        rd(SA6_ENABLE_ADDR, d, resp);
        chk("enable kept", d, {24'h0, en, 3'h0});
        // mid-run reset with flags and enables set
        wr(SA6_ENABLE_ADDR, 32'hF8, resp);
        setc(4'hF);
        setc(4'hE);
        repeat (2) @(posedge clk);
        chk("irq before reset", {31'h0, irq}, {31'h0, |(exp_f & en)});
        nrst <= 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        exp_f = 5'h00;
        en = 5'h00;
        chk("irq reset", {31'h0, irq}, 32'h0);
        rd(SA6_STATUS_ADDR, d, resp);
        chk("status after reset", d, 32'h0);
        rd(SA6_ENABLE_ADDR, d, resp);
        chk("enable after reset", d, 32'h0);
        // Leaving 1110 after reset still flags, every enable off
        setc(4'h0);
        settle_check();
        end_sim();
    end

endmodule

`default_nettype wire
